/* core/bbsc_pkg.sv */
// Package for the battery-backed memory port controller
package bbsc_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	// Device map
	localparam logic [12:0] CLOCK_BASE_ADDR   = 13'h1FF8;
	localparam logic [12:0] CLOCK_CTRL_ADDR   = 13'h1FF8;
	localparam logic [12:0] CLOCK_TOP_ADDR    = 13'h1FFF;
	// Controller registers (APB byte addresses)
	localparam logic [11:0] REG_CMD_OFF    = 12'h000;
	localparam logic [11:0] REG_STATUS_OFF = 12'h004;
	localparam logic [11:0] REG_RDATA_OFF  = 12'h008;
	localparam logic [11:0] REG_TIMING_OFF = 12'h00C;
	// Command register fields
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_DATA_LSB = 16;
	localparam int CMD_WR_BIT   = 24;
	localparam int CMD_GO_BIT   = 31;
	// Status fields
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_DONE_BIT  = 1;
	// Timing in ns, converted to cycles at 4 ns
	localparam int CLK_NS       = 4;
	localparam int T_ACCESS_NS  = 70;
	localparam int T_WPULSE_NS  = 55;
	localparam int T_DSETUP_NS  = 30;
	localparam int T_HOLD_NS    = 5;
	localparam int T_RECOV_NS   = 25;
	localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPULSE_CYC = (T_WPULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int DSETUP_CYC = (T_DSETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC   = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOV_CYC  = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] TIMING_RST = 8'(ACCESS_CYC);

	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_READ   = 5'b00010,
		ST_WRITE  = 5'b00100,
		ST_HOLD   = 5'b01000,
		ST_RECOV  = 5'b10000
	} bbsc_state_t;

	// Pins toward the device
	typedef struct packed {
		logic [12:0] addr;
		logic        select_one_n;
		logic        select_two;
		logic        out_en_n;
		logic        write_n;
		logic [7:0]  byte_lines_out;
		logic        byte_lines_oe;
	} bbsc_pins_t;
endpackage

/* core/bbsc_ctrl.sv */
// Host-side controller for the battery-backed memory and clock port
// What this block does
// - Write starts at last enabling edge, ends at first disabling edge.
// - Host keeps address stable across the whole write cycle.
// - Host sets data before the ending edge, holds briefly after.
// - Host deasserts a control for a recovery time between cycles.
// - Host keeps output enable high during writes.
`timescale 1ns/1ps
`default_nettype none
module bbsc_ctrl
	import bbsc_pkg::*;
#(
	parameter int ADDR_WIDTH = 13
) (
	// Clock, reset, enable
	input  wire logic              ref_clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              clk_en_i,
	// APB slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [11:0]       paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Device pins
	output bbsc_pkg::bbsc_pins_t   pins_o,
	input  wire logic [7:0]        byte_lines_i
);
	import bbsc_pkg::*;

	bbsc_state_t         state_reg;
	logic [7:0]          cnt_reg;
	logic [7:0]          access_reg;
	logic [12:0]         addr_reg;
	logic [7:0]          wdata_reg;
	logic                wr_reg;
	logic [7:0]          rdata_reg;
	logic                done_reg;
	logic [7:0]          sync1_reg;
	logic [7:0]          sync2_reg;
	logic                go;
	logic                apb_wr;
	logic                apb_rd;

	assign apb_wr = psel_i & penable_i & pwrite_i;
	assign apb_rd = psel_i & penable_i & ~pwrite_i;
	assign go = apb_wr && paddr_i == REG_CMD_OFF && pwdata_i[CMD_GO_BIT]
		&& state_reg == ST_IDLE;
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;

	// Byte lines from the device pass two flops
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
		end else if (clk_en_i) begin
			sync1_reg <= byte_lines_i;
			sync2_reg <= sync1_reg;
		end
	end

	// APB read data
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (clk_en_i && psel_i && !penable_i && !pwrite_i) begin
			case (paddr_i)
				REG_CMD_OFF: prdata_o <= {7'h00, wr_reg, wdata_reg,
					3'h0, addr_reg};
				REG_STATUS_OFF: prdata_o <= {30'h0, done_reg,
					state_reg != ST_IDLE};
				REG_RDATA_OFF: prdata_o <= {24'h0, rdata_reg};
				REG_TIMING_OFF: prdata_o <= {24'h0, access_reg};
				default: prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// Access time register, software may lengthen it
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			access_reg <= TIMING_RST;
		end else if (clk_en_i && apb_wr && paddr_i == REG_TIMING_OFF) begin
			access_reg <= (pwdata_i[7:0] < TIMING_RST) ? TIMING_RST
				: pwdata_i[7:0];
		end
	end

	// Command capture; address held for the whole cycle
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_reg  <= 13'h0000;
			wdata_reg <= 8'h00;
			wr_reg    <= 1'b0;
		end else if (clk_en_i && go) begin
			addr_reg  <= pwdata_i[CMD_ADDR_LSB +: 13];
			wdata_reg <= pwdata_i[CMD_DATA_LSB +: 8];
			wr_reg    <= pwdata_i[CMD_WR_BIT];
		end
	end

	// Done flag: set by hardware wins over clear by status read
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_reg <= 1'b0;
		end else if (clk_en_i) begin
			if ((state_reg == ST_HOLD) && cnt_reg == 8'h00)
				done_reg <= 1'b1;
			else if (go || (apb_rd && paddr_i == REG_STATUS_OFF))
				done_reg <= 1'b0;
		end
	end

	// Sequencer
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 8'h00;
			rdata_reg <= 8'h00;
		end else if (clk_en_i) begin
			case (state_reg)
				ST_IDLE: begin
					if (go) begin
						if (pwdata_i[CMD_WR_BIT]) begin
							state_reg <= ST_WRITE;
							cnt_reg   <= 8'(WPULSE_CYC - 1);
						end else begin
							state_reg <= ST_READ;
							// Two extra for the input synchroniser
							cnt_reg   <= access_reg + 8'h01;
						end
					end
				end
				ST_READ: begin
					if (cnt_reg == 8'h00) begin
						rdata_reg <= sync2_reg;
						state_reg <= ST_RECOV;
						cnt_reg   <= 8'(RECOV_CYC - 1);
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				ST_WRITE: begin
					if (cnt_reg == 8'h00) begin
						state_reg <= ST_HOLD;
						cnt_reg   <= 8'(HOLD_CYC - 1);
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				ST_HOLD: begin
					if (cnt_reg == 8'h00) begin
						state_reg <= ST_RECOV;
						cnt_reg   <= 8'(RECOV_CYC - 1);
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				ST_RECOV: begin
					if (cnt_reg == 8'h00)
						state_reg <= ST_IDLE;
					else
						cnt_reg <= cnt_reg - 8'h01;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Pin drive; all from flops
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pins_o <= '{addr: 13'h0000, select_one_n: 1'b1,
				select_two: 1'b0, out_en_n: 1'b1, write_n: 1'b1,
				byte_lines_out: 8'h00, byte_lines_oe: 1'b0};
		end else if (clk_en_i) begin
			pins_o.addr           <= (go) ? pwdata_i[CMD_ADDR_LSB +: 13]
				: addr_reg;
			pins_o.select_two     <= 1'b1;
			pins_o.byte_lines_out <= (go) ? pwdata_i[CMD_DATA_LSB +: 8]
				: wdata_reg;
			case (state_reg)
				ST_IDLE: begin
					pins_o.select_one_n  <= ~go;
					pins_o.write_n       <= ~(go & pwdata_i[CMD_WR_BIT]);
					pins_o.out_en_n      <= ~(go & ~pwdata_i[CMD_WR_BIT]);
					pins_o.byte_lines_oe <= go & pwdata_i[CMD_WR_BIT];
				end
				ST_READ: begin
					pins_o.select_one_n  <= (cnt_reg == 8'h00);
					pins_o.out_en_n      <= (cnt_reg == 8'h00);
					pins_o.write_n       <= 1'b1;
					pins_o.byte_lines_oe <= 1'b0;
				end
				ST_WRITE: begin
					// Strobe rises at end, data and address still held
					pins_o.select_one_n  <= 1'b0;
					pins_o.write_n       <= (cnt_reg == 8'h00);
					pins_o.out_en_n      <= 1'b1;
					pins_o.byte_lines_oe <= 1'b1;
				end
				ST_HOLD: begin
					pins_o.select_one_n  <= (cnt_reg == 8'h00);
					pins_o.write_n       <= 1'b1;
					pins_o.out_en_n      <= 1'b1;
					pins_o.byte_lines_oe <= (cnt_reg != 8'h00);
				end
				default: begin
					pins_o.select_one_n  <= 1'b1;
					pins_o.write_n       <= 1'b1;
					pins_o.out_en_n      <= 1'b1;
					pins_o.byte_lines_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* test/bbsc_chk.sv */
// Assertion checker for the memory port controller
`timescale 1ns/1ps
`default_nettype none
module bbsc_chk
	import bbsc_pkg::*;
(
	// Clock and reset
	input wire logic                 ref_clk_i,
	input wire logic                 rst_n_i,
	// Answers and pins
	input wire logic                 pready_o,
	input wire logic                 pslverr_o,
	input wire bbsc_pkg::bbsc_pins_t pins_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_APB: assert property (pready_o && !pslverr_o)
		else $error("apb answer wrong");
	AST_SEL2: assert property (rst_n_i && $past(rst_n_i) |-> pins_o.select_two)
		else $error("select two low");
	AST_WMODE: assert property (!pins_o.write_n |-> pins_o.out_en_n && pins_o.byte_lines_oe && !pins_o.select_one_n)
		else $error("write mode wrong");
	AST_WPULSE: assert property ($fell(pins_o.write_n) |-> ##13 !pins_o.write_n ##1 pins_o.write_n)
		else $error("write pulse length");
	AST_HOLD: assert property ($rose(pins_o.write_n) |->
		!pins_o.select_one_n && pins_o.byte_lines_oe
		&& $stable(pins_o.byte_lines_out)
		##1 !pins_o.select_one_n && pins_o.byte_lines_oe
		##1 pins_o.select_one_n && !pins_o.byte_lines_oe)
		else $error("write hold wrong");
	AST_ADDR: assert property (!pins_o.select_one_n && !$past(pins_o.select_one_n) |-> $stable(pins_o.addr))
		else $error("address moved");
	AST_RECOV: assert property ($rose(pins_o.select_one_n) && $past(pins_o.byte_lines_oe) |-> pins_o.select_one_n[*7])
		else $error("recovery short");
	AST_READ: assert property ($fell(pins_o.out_en_n) |-> (!pins_o.select_one_n && pins_o.write_n && !pins_o.byte_lines_oe)[*8])
		else $error("read mode wrong");
endmodule
bind bbsc_ctrl bbsc_chk bbsc_chk_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .pins_o(pins_o));
`default_nettype wire

/* test/bbsc_mem_model.sv */
// Behavioural model of the battery-backed memory with clock bytes
`timescale 1ns/1ps
`default_nettype none
module bbsc_mem_model (
	// Device pins
	input  wire logic [12:0] addr_i,
	input  wire logic        select_one_n_i,
	input  wire logic        select_two_i,
	input  wire logic        out_en_n_i,
	input  wire logic        write_n_i,
	input  wire logic [7:0]  byte_lines_i,
	input  wire logic        power_fail_i,
	// Data toward the host
	output logic      [7:0]  byte_lines_o,
	output logic             drive_o
);
	logic [7:0] mem [0:8191];
	wire        wr_act;
	wire        drv_late;
	initial for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
	// Clock bytes at the top eight addresses are plain array cells
	// Their BCD calendar, refresh and battery upkeep are not modelled
	assign wr_act = !write_n_i && !select_one_n_i && select_two_i && !power_fail_i;
	always @(negedge wr_act) mem[addr_i] = byte_lines_i;
	assign drive_o = !power_fail_i && !select_one_n_i && select_two_i && !out_en_n_i && write_n_i;
	assign #70 drv_late = drive_o;
	// Wrong data until the access delay has run
	assign byte_lines_o = (drive_o && drv_late) ? mem[addr_i] : ~mem[addr_i];
endmodule
`default_nettype wire

/* test/tb_bbsc_ctrl.sv */
// Self-checking testbench for the memory port controller
`timescale 1ns/1ps
`default_nettype none
module tb_bbsc_ctrl;
	import bbsc_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        pf = 1'b0;
	logic        clk_en = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	bbsc_pins_t  pins;
	wire  [7:0]  dq;
	wire  [7:0]  dev_q;
	wire         dev_drv;
	logic [7:0]  exp_mem [0:8191];
	int          n_fail = 0;
	int          num_checks = 0;
	int          seed = 32'h7099;
	assign dq = (pins.byte_lines_oe && !dev_drv) ? pins.byte_lines_out : dev_q;
	initial forever #2 ref_clk_i = ~ref_clk_i;
	bbsc_ctrl bbsc_ctrl_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(),
		.pins_o(pins), .byte_lines_i(dq));
	bbsc_mem_model bbsc_mem_model_inst (.addr_i(pins.addr), .select_one_n_i(pins.select_one_n),
		.select_two_i(pins.select_two), .out_en_n_i(pins.out_en_n), .write_n_i(pins.write_n),
		.byte_lines_i(dq), .power_fail_i(pf), .byte_lines_o(dev_q), .drive_o(dev_drv));
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] cmd(input logic wr, input logic [12:0] ad, input logic [7:0] wd);
		cmd = 32'h0;
		cmd[CMD_GO_BIT] = 1'b1;
		cmd[CMD_WR_BIT] = wr;
		cmd[CMD_DATA_LSB +: 8] = wd;
		cmd[CMD_ADDR_LSB +: 13] = ad;
	endfunction
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] q);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		do @(posedge ref_clk_i); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task automatic dev(input logic wr, input logic [12:0] ad, input logic [7:0] wd);
		logic [31:0] q;
		apb(1'b1, REG_CMD_OFF, cmd(wr, ad, wd), q);
		do apb(1'b0, REG_STATUS_OFF, 32'h0, q); while (q[ST_BUSY_BIT] !== 1'b0);
		if (wr && !pf)
			exp_mem[ad] = wd;
	endtask
	task automatic rd_chk(input logic [12:0] ad);
		logic [31:0] q;
		dev(1'b0, ad, 8'h00);
		apb(1'b0, REG_RDATA_OFF, 32'h0, q);
		chk(q, {24'h0, exp_mem[ad]});
	endtask
	initial begin
		#100000;
		n_fail++;
		end_of_test;
	end
	initial begin
		logic [31:0] q;
		logic [12:0] a;
		for (int i = 0; i < 8192; i++) exp_mem[i] = 8'h00;
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		@(posedge ref_clk_i);
		apb(1'b0, REG_TIMING_OFF, 32'h0, q);
		chk(q, {24'h0, TIMING_RST});
		apb(1'b1, REG_TIMING_OFF, 32'h5, q);
		apb(1'b1, 12'h010, 32'hFF, q);
		apb(1'b0, 12'h010, 32'h0, q);
		chk(q, 32'h0);
		apb(1'b0, REG_TIMING_OFF, 32'h0, q);
		chk(q, {24'h0, TIMING_RST});
		// Both array ends and every clock byte, then random places
		for (int i = 0; i < 20; i++) begin
			a = (i < 8) ? CLOCK_BASE_ADDR + 13'(i) : (i == 8) ? 13'h0000 : (i == 9) ? 13'h1FF7 : 13'($random(seed));
			dev(1'b1, a, 8'($random(seed)));
			rd_chk(a);
		end
		for (int i = 0; i < 8; i++) rd_chk(CLOCK_BASE_ADDR + 13'(i));
		// Second order while busy is refused
		apb(1'b1, REG_CMD_OFF, cmd(1'b1, 13'h0123, 8'h5A), q);
		exp_mem[13'h0123] = 8'h5A;
		q[7:0] = exp_mem[13'h0124];
		dev(1'b1, 13'h0124, 8'hA5);
		exp_mem[13'h0124] = q[7:0];
		rd_chk(13'h0124);
		rd_chk(13'h0123);
		// Writes lost while the supply is out of tolerance
		pf <= 1'b1;
		dev(1'b1, CLOCK_CTRL_ADDR, ~exp_mem[CLOCK_CTRL_ADDR]);
		pf <= 1'b0;
		rd_chk(CLOCK_CTRL_ADDR);
		apb(1'b1, REG_TIMING_OFF, 32'h14, q);
		apb(1'b0, REG_TIMING_OFF, 32'h0, q);
		chk(q, 32'h14);
		rd_chk(CLOCK_TOP_ADDR);
		// A frozen controller ignores a register write
		clk_en <= 1'b0;
		apb(1'b1, REG_TIMING_OFF, 32'h30, q);
		clk_en <= 1'b1;
		apb(1'b0, REG_TIMING_OFF, 32'h0, q);
		chk(q, 32'h14);
		end_of_test;
	end
endmodule
`default_nettype wire
